// File: rtl/serial_bus_phy_base_registers.sv
// Base register bank of the two-port cable PHY core, reached over APB
`timescale 1ns/100ps
`default_nettype none

module serial_bus_phy_base_registers
  import phy_base_regs_pkg::*;
#(
  parameter int LONG_RESET_CYCLES = LONG_RESET_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [APB_AW-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 selfIdValid,
  input  wire logic [5:0]           selfIdNode,
  input  wire logic                 selfIdRoot,
  input  wire logic                 cablePowerPin,
  input  wire logic                 link_power_status_signal,
  input  wire logic                 contenderStrap,
  input  wire logic                 supply_category_strap0,
  input  wire logic                 supply_category_strap1,
  input  wire logic                 supply_category_strap2,
  output logic                      forceRoot,
  output logic                      busResetActive,
  output logic [5:0]                gapCount,
  output logic                      linkTxBlocked,
  output selfid_fields_t            selfIdFields
);

  // ==========================================================================
  // Register map, one byte per 32-bit word, upper bits read zero
  // ==========================================================================
  // 0x00 node number [7:2], root [1], cable power ok [0]
  // 0x04 root holdoff [7], long reset request and busy [6], gap setting [5:0]
  // 0x08 map type [7:5], port count [3:0]
  // 0x0C speed code [7:5], repeater delay code [3:0]
  // 0x10 link active [7], contender [6], jitter code [5:3], power class [2:0]
  // 0x20 status: transmit blocked [1], long reset in progress [0]
  // Anything else answers with pslverr and changes nothing

  // ==========================================================================
  // Synchronisers for pins from outside the clock domain
  // ==========================================================================
  // Only the second stage is read; the first may go metastable on a pin edge
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  wire  [5:0] pinsRaw = {cablePowerPin, link_power_status_signal, contenderStrap,
                         supply_category_strap2, supply_category_strap1,
                         supply_category_strap0};
  wire        powerOkSync   = syncB_reg[5];
  wire        linkPowerSync = syncB_reg[4];
  wire        contSync      = syncB_reg[3];
  wire  [2:0] classSync     = syncB_reg[2:0];

  always_ff @(posedge core_clk) begin
    syncA_reg <= pinsRaw;
    syncB_reg <= syncA_reg;
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [5:0]  node_number_reg;
  logic        root_reg;
  logic        cable_power_ok_reg;
  logic        root_holdoff_reg;
  logic [5:0]  gap_reg;
  logic        link_active_control_reg;
  logic        contender_reg;
  logic [2:0]  power_class_reg;
  // Strap capture bookkeeping and the long reset timer
  logic        strapPending_reg;
  logic [31:0] resetCnt_reg;
  logic        resetBusy_reg;

  // ==========================================================================
  // APB decode; one-cycle answer, access phase completes at once
  // ==========================================================================
  wire        access     = psel && penable;
  wire        wrAccess   = access && pwrite && pstrb[0];
  wire        wordAlign  = (paddr[1:0] == 2'h0);
  wire [2:0]  regIdx     = paddr[4:2];
  wire        inBank     = wordAlign && (paddr[APB_AW-1:5] == '0)
                           && (regIdx < 3'(IDX_COUNT));
  wire        isStatus   = (paddr == ADDR_STATUS);
  wire        mapped     = inBank || isStatus;
  // Address and direction are sampled in setup; writes land in the access cycle
  wire        setupCyc   = psel && !penable;
  wire [7:0]  wByte      = pwdata[7:0];

  // Write fields picked out once, so each register block below is a plain load
  wire        wrHoldoff  = wByte[BIT_HOLDOFF];
  wire        wrLongBit  = wByte[BIT_LONG_RESET];
  wire [5:0]  wrGap      = wByte[GAP_MSB:0];
  wire        wrLinkBit  = wByte[BIT_LINK_ACT];
  wire        wrContBit  = wByte[BIT_CONTENDER];
  wire [2:0]  wrClass    = wByte[CLASS_MSB:0];

  function automatic logic hit(input logic [2:0] idx);
    hit = wrAccess && inBank && (regIdx == idx);
  endfunction : hit

  wire        wrCtrl       = hit(IDX_CTRL);
  wire        wrSelfId     = hit(IDX_SELFID);
  wire        longResetReq = wrCtrl && wrLongBit;

  // Read bytes; read-only bytes are built from constants and status only
  wire [7:0] rdNode   = {node_number_reg, root_reg, cable_power_ok_reg};
  wire [7:0] rdCtrl   = {root_holdoff_reg, resetBusy_reg, gap_reg};
  wire [7:0] rdPorts  = {MAP_TYPE_EXT, 1'b0, PORT_COUNT};
  wire [7:0] rdSpeed  = {SPEED_S400, 1'b0, REPEAT_DELAY};
  wire [7:0] rdSelfId = {link_active_control_reg, contender_reg, JITTER_CODE,
                         power_class_reg};
  wire [7:0] rdStatus = {6'h00, linkTxBlocked, busResetActive};

  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (isStatus) begin
      rdByte = rdStatus;
    end else if (inBank) begin
      unique case (regIdx)
        IDX_NODE:   rdByte = rdNode;
        IDX_CTRL:   rdByte = rdCtrl;
        IDX_PORTS:  rdByte = rdPorts;
        IDX_SPEED:  rdByte = rdSpeed;
        IDX_SELFID: rdByte = rdSelfId;
        default:    rdByte = 8'h00;
      endcase
    end
  end

  // No wait states: the answer is ready in the first access cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setupCyc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupCyc && !mapped;
    end
  end

  // Data is zero outside a read answer so stale bytes never linger on the bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (setupCyc && !pwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Node identity, root and cable power status
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (reset) begin
      node_number_reg <= NODE_RESET;
      root_reg        <= 1'b0;
    end else if (selfIdValid) begin
      node_number_reg <= selfIdNode;
      root_reg        <= selfIdRoot;
    end
  end

  // The threshold comparator sits outside; this bit only follows its settled level
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cable_power_ok_reg <= 1'b0;
    end else begin
      cable_power_ok_reg <= powerOkSync;
    end
  end

  // ==========================================================================
  // Control: root holdoff, gap setting, long reset
  // ==========================================================================
  // Holdoff only asks for root at the next tree identify; it never starts one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      root_holdoff_reg <= 1'b0;
    end else if (wrCtrl) begin
      root_holdoff_reg <= wrHoldoff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gap_reg <= GAP_RESET;
    end else if (wrCtrl) begin
      gap_reg <= wrGap;
    end
  end

  // Bit self-clears: the busy flag stands for the reset time and then drops.
  // A new request while busy restarts the full time rather than being lost.
  wire resetDone = resetBusy_reg && (resetCnt_reg == 32'h0000_0000);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      resetBusy_reg <= 1'b0;
    end else if (longResetReq) begin
      resetBusy_reg <= 1'b1;
    end else if (resetDone) begin
      resetBusy_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      resetCnt_reg <= 32'h0000_0000;
    end else if (longResetReq) begin
      resetCnt_reg <= 32'(LONG_RESET_CYCLES - 1);
    end else if (resetBusy_reg && !resetDone) begin
      resetCnt_reg <= resetCnt_reg - 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Self-ID fields; straps caught on the third cycle after reset release
  // ==========================================================================
  // Straps pass the synchroniser first, so the capture waits on pipeline fill
  logic [1:0] strapWait_reg;
  wire        strapCapture = strapPending_reg && (strapWait_reg == 2'(STRAP_SETTLE));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      strapPending_reg <= 1'b1;
      strapWait_reg    <= 2'h0;
    end else if (wrSelfId || strapCapture) begin
      strapPending_reg <= 1'b0;
    end else if (strapPending_reg) begin
      strapWait_reg <= strapWait_reg + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_active_control_reg <= LINK_ACT_RESET;
    end else if (wrSelfId) begin
      link_active_control_reg <= wrLinkBit;
    end
  end

  // A software write before the straps settle wins; later strap moves are ignored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      contender_reg <= 1'b0;
    end else if (wrSelfId) begin
      contender_reg <= wrContBit;
    end else if (strapCapture) begin
      contender_reg <= contSync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      power_class_reg <= 3'h0;
    end else if (wrSelfId) begin
      power_class_reg <= wrClass;
    end else if (strapCapture) begin
      power_class_reg <= classSync;
    end
  end

  // ==========================================================================
  // Outputs to the PHY core and link
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (reset) begin
      forceRoot <= 1'b0;
    end else begin
      forceRoot <= root_holdoff_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busResetActive <= 1'b0;
    end else begin
      busResetActive <= resetBusy_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gapCount <= GAP_RESET;
    end else begin
      gapCount <= gap_reg;
    end
  end

  // Blocking follows the stored number, so a later self-ID result lifts it again
  always_ff @(posedge core_clk) begin
    if (reset) begin
      linkTxBlocked <= 1'b0;
    end else begin
      linkTxBlocked <= (node_number_reg == NODE_MISCONFIG);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      selfIdFields <= '0;
    end else begin
      selfIdFields.linkActive <= link_active_control_reg && linkPowerSync;
      selfIdFields.contender  <= contender_reg;
      selfIdFields.powerClass <= power_class_reg;
    end
  end

endmodule : serial_bus_phy_base_registers

`default_nettype wire

// File: rtl/phy_base_regs_pkg.sv
// Package: register offsets, field layout, reset values and timing for the PHY base registers
package phy_base_regs_pkg;

  // ==========================================================================
  // Register index (byte-wide PHY registers), APB byte address = index * 4
  // ==========================================================================
  localparam logic [2:0] IDX_NODE    = 3'h0;
  localparam logic [2:0] IDX_CTRL    = 3'h1;
  localparam logic [2:0] IDX_PORTS   = 3'h2;
  localparam logic [2:0] IDX_SPEED   = 3'h3;
  localparam logic [2:0] IDX_SELFID  = 3'h4;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  localparam int          IDX_COUNT   = 5;
  localparam int          APB_AW      = 12;

  // ==========================================================================
  // Constant capability fields
  // ==========================================================================
  localparam logic [2:0] MAP_TYPE_EXT   = 3'h7;
  localparam logic [3:0] PORT_COUNT     = 4'h2;
  localparam logic [2:0] SPEED_S400     = 3'h2;
  localparam logic [3:0] REPEAT_DELAY   = 4'h0;
  localparam logic [2:0] JITTER_CODE    = 3'h0;

  // ==========================================================================
  // Reset values and special codes
  // ==========================================================================
  localparam logic [5:0] NODE_RESET     = 6'h00;
  localparam logic [5:0] NODE_MISCONFIG = 6'h3F;
  localparam logic [5:0] GAP_RESET      = 6'h3F;
  localparam logic       LINK_ACT_RESET = 1'b1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ         = 40;
  localparam int LONG_RESET_US   = 166;
  localparam int LONG_RESET_CYC  = LONG_RESET_US * CLK_MHZ;
  localparam int STRAP_SETTLE    = 2;

  // ==========================================================================
  // Field positions within the data byte
  // ==========================================================================
  localparam int BIT_HOLDOFF     = 7;
  localparam int BIT_LONG_RESET  = 6;
  localparam int GAP_MSB         = 5;
  localparam int BIT_LINK_ACT    = 7;
  localparam int BIT_CONTENDER   = 6;
  localparam int CLASS_MSB       = 2;

  // ==========================================================================
  // Field carriers
  // ==========================================================================
  typedef struct packed {
    logic       linkActive;
    logic       contender;
    logic [2:0] powerClass;
  } selfid_fields_t;

  typedef struct packed {
    logic [5:0] nodeNumber;
    logic       isRoot;
    logic       valid;
  } selfid_result_t;

endpackage : phy_base_regs_pkg

// File: bench/phy_base_regs_asserts.sv
// Port checker for the PHY base register bank
`timescale 1ns/100ps
`default_nettype none
module phy_base_regs_asserts
  import phy_base_regs_pkg::*;
#(
  parameter int LONG_RESET_CYCLES = 20
) (
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              selfIdValid,
  input wire logic [5:0]        selfIdNode,
  input wire logic              forceRoot,
  input wire logic              busResetActive,
  input wire logic [5:0]        gapCount,
  input wire logic              linkTxBlocked
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic [5:0] lastGap_reg;
  int         busyCnt_reg;
  wire logic  access = psel && penable && pready;
  wire logic  ctrlWr = access && pwrite && pstrb[0] && paddr == 12'h004;
  wire logic  rdAcc  = access && !pwrite;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence setupPhase;
    psel && !penable;
  endsequence
  always_ff @(posedge core_clk) begin
    if (ctrlWr) lastGap_reg <= pwdata[5:0];
    busyCnt_reg <= busResetActive ? busyCnt_reg + 1 : 0;
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  answer_next_a: assert property (setupPhase |=> pready)
    else $error("no answer after setup");
  gap_update_a: assert property (ctrlWr |=> ##[0:1] gapCount == lastGap_reg)
    else $error("gap setting not applied");
  holdoff_on_a: assert property (ctrlWr && pwdata[7] |-> ##[1:2] forceRoot)
    else $error("force root not raised");
  long_start_a: assert property (ctrlWr && pwdata[6] |-> ##[1:2] busResetActive)
    else $error("long reset not started");
  long_len_a: assert property ($fell(busResetActive) |-> busyCnt_reg == LONG_RESET_CYCLES)
    else $error("long reset length wrong");
  node_blocked_a: assert property (selfIdValid && selfIdNode == 6'h3F |-> ##[1:3] linkTxBlocked)
    else $error("misconfigured node not blocked");
  const_ports_a: assert property (rdAcc && paddr == 12'h008 |-> prdata == 32'h000000E2)
    else $error("ports byte wrong");
  const_speed_a: assert property (rdAcc && paddr == 12'h00C |-> prdata == 32'h00000040)
    else $error("speed byte wrong");
  reset_vals_a: assert property ($fell(reset) |-> gapCount == GAP_RESET && !forceRoot)
    else $error("reset values wrong");
endmodule : phy_base_regs_asserts

bind serial_bus_phy_base_registers phy_base_regs_asserts #(
  .LONG_RESET_CYCLES(LONG_RESET_CYCLES)
) phy_base_regs_asserts_inst (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .selfIdValid, .selfIdNode, .forceRoot, .busResetActive,
  .gapCount, .linkTxBlocked);
`default_nettype wire

// File: bench/link_side_model.sv
// Model of the self-ID logic and pin levels that feed the register bank
`timescale 1ns/100ps
`default_nettype none
module link_side_model (
  input  wire logic core_clk,
  output logic       selfIdValid,
  output logic [5:0] selfIdNode,
  output logic       selfIdRoot,
  output logic       cablePower,
  output logic       linkPower,
  output logic       contender,
  output logic [2:0] supplyCat
);
  // ==========================================================================
  // Pin levels
  // ==========================================================================
  task automatic setPins(input logic cp, input logic lp, input logic ct, input logic [2:0] sc);
    selfIdValid <= 1'b0;
    cablePower  <= cp;
    linkPower   <= lp;
    contender   <= ct;
    supplyCat   <= sc;
  endtask : setPins
  // Result fields are inverted after the pulse so a stale value cannot pass for a load
  task automatic announce(input logic [5:0] node, input logic root);
    @(posedge core_clk);
    selfIdValid <= 1'b1;
    selfIdNode  <= node;
    selfIdRoot  <= root;
    @(posedge core_clk);
    selfIdValid <= 1'b0;
    selfIdNode  <= ~node;
    selfIdRoot  <= ~root;
  endtask : announce
endmodule : link_side_model
`default_nettype wire

// File: bench/serial_bus_phy_base_registers_tb.sv
// Self-checking bench for the PHY base register bank
`timescale 1ns/100ps
`default_nettype none
module serial_bus_phy_base_registers_tb;
  import phy_base_regs_pkg::*;
  localparam int LRC = 20;
  logic              core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              sidV, sidR, cPow, lPow, cont, forceRoot, busResetActive, linkTxBlocked;
  logic [5:0]        sidN, gapCount, n;
  logic [2:0]        sCat;
  logic [7:0]        v, ctrlMdl, sidMdl;
  selfid_fields_t    selfIdFields;
  int                n_errors = 0;
  int                n_checks = 0;
  int                cycles = 0;
  int                busyLen = 0;
  serial_bus_phy_base_registers #(.LONG_RESET_CYCLES(LRC)) serial_bus_phy_base_registers_inst (
    .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .selfIdValid(sidV), .selfIdNode(sidN), .selfIdRoot(sidR), .cablePowerPin(cPow),
    .link_power_status_signal(lPow), .contenderStrap(cont), .supply_category_strap0(sCat[0]),
    .supply_category_strap1(sCat[1]), .supply_category_strap2(sCat[2]), .forceRoot,
    .busResetActive, .gapCount, .linkTxBlocked, .selfIdFields);
  link_side_model link_side_model_inst (.core_clk, .selfIdValid(sidV), .selfIdNode(sidN),
    .selfIdRoot(sidR), .cablePower(cPow), .linkPower(lPow), .contender(cont), .supplyCat(sCat));
  // ==========================================================================
  // Clock, watchdog and helpers
  // ==========================================================================
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (busResetActive === 1'b1) busyLen <= busyLen + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Request held until pready is sampled high; the wait is cut only by the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdChk(input logic [11:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, $urandom, 4'hF);
    chk(what, rd, {24'h0, exp});
    chk("error flag", 32'(err), 32'h0);
  endtask : rdChk
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(32'h79DA41EA));
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    reset = 1'b1;
    v = 8'($urandom);
    // Outer strap bits kept equal so the class value does not depend on strap ordering
    link_side_model_inst.setPins(1'b0, 1'b1, v[0], {v[1], v[2], v[1]});
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    sidMdl = {2'b10 | {1'b0, v[0]}, 3'b000, v[1], v[2], v[1]};
    rdChk(12'h000, 8'h00, "node");
    rdChk(12'h004, 8'h3F, "ctrl");
    rdChk(12'h008, 8'hE2, "ports");
    rdChk(12'h00C, 8'h40, "speed");
    rdChk(12'h010, sidMdl, "selfid");
    chk("fields", 32'(selfIdFields), {27'h0, sidMdl[7:6], sidMdl[2:0]});
    ctrlMdl = 8'($urandom) | 8'hC0;
    busyLen = 0;
    apb(1'b1, 12'h004, {24'($urandom), ctrlMdl}, 4'hF);
    rdChk(12'h004, ctrlMdl, "ctrl busy");
    chk("force root", 32'(forceRoot), 32'h1);
    chk("gap", 32'(gapCount), 32'(ctrlMdl[5:0]));
    while (busResetActive !== 1'b0) @(posedge core_clk);
    chk("reset length", busyLen, LRC);
    rdChk(12'h004, ctrlMdl & 8'hBF, "ctrl done");
    apb(1'b1, 12'h004, 32'h0000000A, 4'h0);
    rdChk(12'h004, ctrlMdl & 8'hBF, "ctrl no strobe");
    apb(1'b1, 12'h008, $urandom, 4'hF);
    rdChk(12'h008, 8'hE2, "ports");
    apb(1'b1, 12'h004, 32'h0000000A, 4'hF);
    repeat (2) @(posedge core_clk);
    chk("holdoff off", 32'({forceRoot, gapCount}), 32'h0A);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, (i == 0) ? 12'h014 : (i == 1) ? 12'h005 : 12'h01C, 32'h0, 4'hF);
      chk("unmapped", 32'(err), 32'h1);
    end
    sidMdl = 8'($urandom) & 8'hC7;
    apb(1'b1, 12'h010, {24'hFFFFFF, sidMdl | 8'h38}, 4'hF);
    // Straps move after power-up; the stored self-ID fields must not follow them
    link_side_model_inst.setPins(1'b1, 1'b0, ~v[0], ~{v[1], v[2], v[1]});
    repeat (4) @(posedge core_clk);
    rdChk(12'h010, sidMdl, "selfid");
    chk("fields", 32'(selfIdFields), {27'h0, 1'b0, sidMdl[6], sidMdl[2:0]});
    n = 6'($urandom % 63);
    link_side_model_inst.announce(n, 1'b1);
    repeat (4) @(posedge core_clk);
    rdChk(12'h000, {n, 2'b11}, "node");
    rdChk(12'h020, 8'h00, "status");
    link_side_model_inst.setPins(1'b0, 1'b0, ~v[0], ~{v[1], v[2], v[1]});
    link_side_model_inst.announce(6'h3F, 1'b0);
    repeat (5) @(posedge core_clk);
    chk("blocked", 32'(linkTxBlocked), 32'h1);
    rdChk(12'h000, 8'hFC, "node");
    rdChk(12'h020, 8'h02, "status");
    give_verdict();
  end
endmodule : serial_bus_phy_base_registers_tb
`default_nettype wire
